// file: hw/angle_status_ctrl_regs.sv
// status, control, cosine and angle registers of the angle sensor
//------------------------------------------------------------
// What this block does
//------------------------------------------------------------
`timescale 1ns/100ps
module angle_status_ctrl_regs
    import angle_regs_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] rdata_o,
    input  wire logic [15:0] cos_p_i,
    input  wire logic [15:0] angle_p_i,
    input  wire logic [15:0] angle_s_i,
    input  wire logic        angle_upd_p_i,
    input  wire logic        angle_upd_s_i,
    input  wire logic        low_power_i,
    input  wire logic        angle_decr_i,
    input  wire logic        slew_forced_i,
    input  wire logic        slew_enable_i,
    input  wire logic        seq_violation_i,
    input  wire logic        cntup_done_i,
    input  wire logic [5:0]  encoder_slew_setting_i,
    input  wire logic        loss_power_en_i,
    input  wire logic [10:0] turns_reg_p_i,
    input  wire logic [10:0] turns_reg_s_i,
    input  wire logic [15:0] turns_cfg_p_i,
    input  wire logic [15:0] turns_cfg_s_i,
    input  wire logic [10:0] turns_cnt_p_i,
    input  wire logic [10:0] turns_cnt_s_i,
    input  wire logic        err_cause_gone_i,
    input  wire logic        err_read_i,
    output logic             eeprom_reload_o,
    output logic             logic_reset_o,
    output logic             reset_occurred_o,
    output logic             turns_load_o,
    output logic [10:0]      turns_load_p_o,
    output logic [10:0]      turns_load_s_o,
    output logic [15:0]      angle_s_latch_o,
    output logic [10:0]      turns_p_latch_o,
    output logic [10:0]      turns_s_latch_o
);
    typedef enum logic [1:0] {RS_IDLE, RS_SOFT, RS_FULL} rst_state_t;
    rst_state_t rst_state_r;
    logic [3:0] rst_cnt_r;
    logic       back_lp_r, slew_r, integ_r, cntup_r, valid_r, rot_r;
    logic       seen_p_r, seen_s_r, was_lp_r, pend_back_r;
    logic       tcwe_r, tcclr_r;
    logic       st_rd, ct_wr, ang_rd, rst_done, local_rst;

    assign st_rd     = rd_i && addr_i == ADDR_STATUS;
    assign ct_wr     = wr_i && addr_i == ADDR_CTRL;
    assign ang_rd    = rd_i && addr_i == ADDR_ANGLE_P;
    assign rst_done  = rst_state_r != RS_IDLE && rst_cnt_r == RESET_CYCLES;
    assign local_rst = !rstn_i || rst_state_r != RS_IDLE;

    function automatic logic [10:0] init_val(input logic [15:0] cfg);
        init_val = cfg[INIT_SEL_BIT] ? TURNS_INIT_ONE : TURNS_INIT_ZERO;
    endfunction

    //------------------------------------------------------------
    // reset sequencer
    //------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rst_state_r <= RS_IDLE;
            rst_cnt_r   <= 4'h0;
        end else begin
            case (rst_state_r)
                RS_IDLE: begin
                    rst_cnt_r <= 4'h0;
                    if (ct_wr && wdata_i[CT_FULL]) begin
                        rst_state_r <= RS_FULL;
                    end else if (ct_wr && wdata_i[CT_SOFT]) begin
                        rst_state_r <= RS_SOFT;
                    end
                end
                RS_SOFT, RS_FULL: begin
                    rst_cnt_r <= rst_cnt_r + 4'h1;
                    if (rst_done) begin
                        rst_state_r <= RS_IDLE;
                    end
                end
                default: rst_state_r <= RS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            eeprom_reload_o <= 1'b0;
            logic_reset_o   <= 1'b0;
        end else begin
            eeprom_reload_o <= rst_state_r == RS_FULL && !rst_done;
            logic_reset_o   <= rst_state_r != RS_IDLE && !rst_done;
        end
    end

    // reset-occurred flag kept until read with cause gone
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            reset_occurred_o <= 1'b1;
        end else if (rst_done) begin
            reset_occurred_o <= 1'b1;
        end else if (err_read_i && err_cause_gone_i) begin
            reset_occurred_o <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // status flags
    //------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (local_rst) begin
            back_lp_r   <= 1'b0;
            slew_r      <= 1'b0;
            integ_r     <= 1'b0;
            cntup_r     <= 1'b0;
            valid_r     <= 1'b0;
            rot_r       <= 1'b0;
            seen_p_r    <= 1'b0;
            seen_s_r    <= 1'b0;
            was_lp_r    <= 1'b0;
            pend_back_r <= 1'b0;
        end else begin
            rot_r    <= angle_decr_i;
            was_lp_r <= low_power_i;
            if (low_power_i) begin
                valid_r  <= 1'b0;
                seen_p_r <= 1'b0;
                seen_s_r <= 1'b0;
            end else begin
                seen_p_r <= seen_p_r | angle_upd_p_i;
                seen_s_r <= seen_s_r | angle_upd_s_i;
                if ((seen_p_r | angle_upd_p_i) && (seen_s_r | angle_upd_s_i)) begin
                    valid_r <= 1'b1;
                end
            end
            if (was_lp_r && !low_power_i) begin
                pend_back_r <= 1'b1;
            end else if (pend_back_r && angle_upd_p_i) begin
                pend_back_r <= 1'b0;
            end
            if (pend_back_r && angle_upd_p_i && !low_power_i) begin
                back_lp_r <= 1'b1;
            end else if (st_rd) begin
                back_lp_r <= 1'b0;
            end
            if (slew_enable_i && slew_forced_i) begin
                slew_r <= 1'b1;
            end else if (st_rd) begin
                slew_r <= 1'b0;
            end
            if (!slew_r && seq_violation_i) begin
                integ_r <= 1'b1;
            end
            if (cntup_done_i && encoder_slew_setting_i != SLEW_OFF) begin
                cntup_r <= 1'b1;
            end else if (st_rd) begin
                cntup_r <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------
    // turns counter control
    //------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (local_rst) begin
            tcwe_r         <= 1'b0;
            tcclr_r        <= 1'b0;
            turns_load_o   <= 1'b0;
            turns_load_p_o <= TURNS_W0;
            turns_load_s_o <= TURNS_W0;
        end else begin
            tcwe_r       <= ct_wr && wdata_i[CT_TCWE] && loss_power_en_i;
            tcclr_r      <= ct_wr && wdata_i[CT_TCCLR];
            turns_load_o <= tcwe_r || tcclr_r;
            if (tcclr_r) begin
                turns_load_p_o <= init_val(turns_cfg_p_i);
                turns_load_s_o <= init_val(turns_cfg_s_i);
            end else if (tcwe_r) begin
                turns_load_p_o <= turns_reg_p_i;
                turns_load_s_o <= turns_reg_s_i;
            end
        end
    end

    //------------------------------------------------------------
    // coherent latches on angle read
    //------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (local_rst) begin
            angle_s_latch_o <= ZERO16;
            turns_p_latch_o <= TURNS_W0;
            turns_s_latch_o <= TURNS_W0;
        end else if (ang_rd) begin
            angle_s_latch_o <= angle_s_i;
            turns_p_latch_o <= turns_cnt_p_i;
            turns_s_latch_o <= turns_cnt_s_i;
        end
    end

    //------------------------------------------------------------
    // read data
    //------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rdata_o <= ZERO16;
        end else begin
            rdata_o <= ZERO16;
            case (addr_i)
                ADDR_COS_P:   rdata_o <= cos_p_i;
                ADDR_ANGLE_P: rdata_o <= angle_p_i;
                ADDR_STATUS: begin
                    rdata_o[ST_BACK_LP] <= back_lp_r;
                    rdata_o[ST_SLEW]    <= slew_r;
                    rdata_o[ST_INTEG]   <= integ_r;
                    rdata_o[ST_CNTUP]   <= cntup_r;
                    rdata_o[ST_ROT]     <= rot_r;
                    rdata_o[ST_VALID]   <= valid_r;
                end
                ADDR_CTRL: begin
                    rdata_o[CT_FULL] <= rst_state_r == RS_FULL;
                    rdata_o[CT_SOFT] <= rst_state_r == RS_SOFT;
                    rdata_o[CT_TCWE] <= tcwe_r;
                end
                default: rdata_o <= ZERO16;
            endcase
        end
    end

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    chk_integ_sticky: assert property (@(posedge clk_sys_i) disable iff (local_rst)
        integ_r |=> integ_r) else $error("integrity flag dropped");
    chk_slew_set: assert property (@(posedge clk_sys_i) disable iff (local_rst)
        slew_enable_i && slew_forced_i |=> slew_r) else $error("slew flag not set");
    chk_back_clear: assert property (@(posedge clk_sys_i) disable iff (local_rst)
        st_rd && !(pend_back_r && angle_upd_p_i) |=> !back_lp_r) else $error("back flag kept");
    chk_cntup_off: assert property (@(posedge clk_sys_i) disable iff (local_rst)
        !cntup_r && encoder_slew_setting_i == SLEW_OFF |=> !cntup_r) else $error("count-up set");
    chk_reset_done: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        rst_done |=> reset_occurred_o && rst_state_r == RS_IDLE) else $error("reset flag missing");
    chk_full_seq: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        rst_state_r == RS_IDLE && ct_wr && wdata_i[CT_FULL]
        |=> rst_state_r == RS_FULL ##9 rst_state_r == RS_IDLE)
        else $error("full reset stuck");
    chk_tc_gate: assert property (@(posedge clk_sys_i) disable iff (local_rst)
        ct_wr && !loss_power_en_i |=> !tcwe_r) else $error("turns write without feature");
    chk_latch_coh: assert property (@(posedge clk_sys_i) disable iff (local_rst)
        ang_rd |=> angle_s_latch_o == $past(angle_s_i)) else $error("latch incoherent");
    chk_valid_set: assert property (@(posedge clk_sys_i) disable iff (local_rst)
        !low_power_i && angle_upd_p_i && angle_upd_s_i |=> valid_r)
        else $error("angle not valid");
    chk_valid_drop: assert property (@(posedge clk_sys_i) disable iff (local_rst)
        low_power_i |=> !valid_r) else $error("valid kept in low power");
    chk_slew_clear: assert property (@(posedge clk_sys_i) disable iff (local_rst)
        st_rd && !(slew_enable_i && slew_forced_i) |=> !slew_r) else $error("slew flag kept");
    chk_cntup_keep: assert property (@(posedge clk_sys_i) disable iff (local_rst)
        cntup_done_i && encoder_slew_setting_i != SLEW_OFF |=> cntup_r)
        else $error("count-up flag lost");
    chk_rot_follow: assert property (@(posedge clk_sys_i) disable iff (local_rst)
        angle_decr_i != rot_r |=> rot_r == $past(angle_decr_i)) else $error("direction stale");
    chk_status_zero: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        addr_i == ADDR_STATUS |=> rdata_o[15:ST_BACK_LP + 1] == '0 && !rdata_o[ST_SLEW + 1])
        else $error("status spare bits set");
    chk_ctrl_zero: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        addr_i == ADDR_CTRL |=> rdata_o[15:CT_FULL + 1] == '0) else $error("control high bits");
    chk_rdata_cos: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        addr_i == ADDR_COS_P |=> rdata_o == $past(cos_p_i)) else $error("cosine read wrong");
    chk_soft_start: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        rst_state_r == RS_IDLE && ct_wr && wdata_i[CT_SOFT] |=> ##1 logic_reset_o)
        else $error("soft reset not started");
    chk_soft_no_reload: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        rst_state_r == RS_SOFT |=> !eeprom_reload_o) else $error("reload in soft reset");
    chk_tc_load: assert property (@(posedge clk_sys_i) disable iff (local_rst)
        tcwe_r && !tcclr_r |=> turns_load_o && turns_load_p_o == $past(turns_reg_p_i)
            && turns_load_s_o == $past(turns_reg_s_i)) else $error("turns load wrong");
endmodule // angle_status_ctrl_regs

// file: hw/angle_regs_pkg.sv
// constants for the angle sensor status and control register bank
package angle_regs_pkg;
    localparam logic [7:0] ADDR_COS_P    = 8'h0d;
    localparam logic [7:0] ADDR_STATUS   = 8'h0e;
    localparam logic [7:0] ADDR_CTRL     = 8'h0f;
    localparam logic [7:0] ADDR_ANGLE_P  = 8'h10;
    localparam int ST_BACK_LP   = 6;
    localparam int ST_SLEW      = 4;
    localparam int ST_INTEG     = 3;
    localparam int ST_CNTUP     = 2;
    localparam int ST_ROT       = 1;
    localparam int ST_VALID     = 0;
    localparam int CT_FULL      = 3;
    localparam int CT_SOFT      = 2;
    localparam int CT_TCWE      = 1;
    localparam int CT_TCCLR     = 0;
    localparam int INIT_SEL_BIT = 12;
    localparam logic [15:0] ZERO16   = 16'h0000;
    localparam logic [10:0] TURNS_W0 = 11'h000;
    localparam logic [5:0]  SLEW_OFF = 6'h00;
    localparam logic [10:0] TURNS_INIT_ONE  = 11'h001;
    localparam logic [10:0] TURNS_INIT_ZERO = 11'h000;
    localparam logic [3:0]  RESET_CYCLES    = 4'h8;
endpackage

// file: verif/host_model.sv
// host side model issuing register reads and writes
`timescale 1ns/100ps
module host_model (
    input  wire logic        clk_sys_i,
    input  wire logic [15:0] rdata_i,
    output logic      [7:0]  addr_o,
    output logic             rd_o,
    output logic             wr_o,
    output logic      [15:0] wdata_o
);
    initial begin
        addr_o = 8'h00;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 16'h0000;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_sys_i);
        wr_o    <= 1'b0;
        wdata_o <= ~d;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_sys_i);
        rd_o <= 1'b0;
        #1 d = rdata_i;
    endtask
endmodule // host_model

// file: verif/angle_sensor_status_control_regs_bench.sv
// self-checking bench for the status and control register bank
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module angle_sensor_status_control_regs_bench;
    import angle_regs_pkg::*;
    logic        clk, rstn, lp, decr, s_forced, s_en, lpe, gone, rd, wr, rel, lrst, rocc, tload;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata, rv, cos_p, ang_p, ang_s, cfg_p, lat_a;
    logic [10:0] treg, cnt_p, cnt_s, ld_p, ld_s, lat_p, lat_s;
    logic [5:0]  slew_set;
    logic [4:0]  ev;
    int          num_errors, samples_checked, n, k;
    host_model host (.clk_sys_i(clk), .rdata_i(rdata), .addr_o(addr), .rd_o(rd), .wr_o(wr),
        .wdata_o(wdata));
    angle_status_ctrl_regs dut (.clk_sys_i(clk), .rstn_i(rstn), .addr_i(addr), .rd_i(rd),
        .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata), .cos_p_i(cos_p), .angle_p_i(ang_p),
        .angle_s_i(ang_s), .angle_upd_p_i(ev[0]), .angle_upd_s_i(ev[1]), .low_power_i(lp),
        .angle_decr_i(decr), .slew_forced_i(s_forced), .slew_enable_i(s_en),
        .seq_violation_i(ev[2]), .cntup_done_i(ev[3]), .encoder_slew_setting_i(slew_set),
        .loss_power_en_i(lpe), .turns_reg_p_i(treg), .turns_reg_s_i(treg),
        .turns_cfg_p_i(cfg_p), .turns_cfg_s_i(16'h0000), .turns_cnt_p_i(cnt_p),
        .turns_cnt_s_i(cnt_s), .err_cause_gone_i(gone), .err_read_i(ev[4]),
        .eeprom_reload_o(rel), .logic_reset_o(lrst), .reset_occurred_o(rocc),
        .turns_load_o(tload), .turns_load_p_o(ld_p), .turns_load_s_o(ld_s),
        .angle_s_latch_o(lat_a), .turns_p_latch_o(lat_p), .turns_s_latch_o(lat_s));
    //------------------------------------------------------------
    // helpers
    //------------------------------------------------------------
    task automatic give_verdict();
        if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic pls(input logic [4:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 5'h00;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [15:0] e, input string nm);
        host.rd_reg(a, rv);
        `CHK(nm, e, rv)
    endtask
    // sel high: wait reset end, sel low: wait load pulse
    task automatic wait_for(input logic sel);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (n < 30 && (sel ? lrst : !tload));
        if (sel ? lrst : !tload) begin
            num_errors++;
            give_verdict();
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    //------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------
    initial begin
        {rstn, lp, s_forced, s_en, lpe, ev} = '0;
        {decr, gone} = 2'b11;
        cos_p = 16'h8001; ang_p = 16'hfff0; ang_s = 16'h1234; cfg_p = 16'h1000;
        treg = 11'h123; cnt_p = 11'h2a5; cnt_s = 11'h15a; slew_set = 6'h05;
        num_errors = 0;
        samples_checked = 0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        chk_rd(ADDR_CTRL, ZERO16, "ctrl");
        pls(5'h10);
        @(posedge clk);
        #1 `CHK("reset flag", 1'b0, rocc)
        chk_rd(ADDR_COS_P, 16'h8001, "cos");
        chk_rd(ADDR_ANGLE_P, 16'hfff0, "angle");
        @(posedge clk);
        ang_s <= 16'h4321;
        cnt_p <= 11'h000;
        @(posedge clk);
        #1 `CHK("latch", {16'h1234, 11'h2a5, 11'h15a}, {lat_a, lat_p, lat_s})
        pls(5'h03);
        chk_rd(ADDR_STATUS, 16'h0003, "valid dir");
        @(posedge clk);
        decr <= 1'b0;
        chk_rd(ADDR_STATUS, 16'h0001, "dir up");
        @(posedge clk);
        decr <= 1'b1;
        @(posedge clk);
        lp <= 1'b1;
        repeat (3) @(posedge clk);
        lp <= 1'b0;
        pls(5'h03);
        chk_rd(ADDR_STATUS, 16'h0043, "back lp");
        chk_rd(ADDR_STATUS, 16'h0003, "back lp rd");
        @(posedge clk);
        {s_en, s_forced} <= 2'b11;
        @(posedge clk);
        s_forced <= 1'b0;
        pls(5'h04);
        chk_rd(ADDR_STATUS, 16'h0013, "slew");
        chk_rd(ADDR_STATUS, 16'h0003, "slew rd");
        pls(5'h04);
        chk_rd(ADDR_STATUS, 16'h000b, "integ");
        pls(5'h08);
        chk_rd(ADDR_STATUS, 16'h000f, "cntup");
        chk_rd(ADDR_STATUS, 16'h000b, "cntup rd");
        fork
            host.rd_reg(ADDR_STATUS, rv);
            pls(5'h08);
        join
        chk_rd(ADDR_STATUS, 16'h000f, "set wins");
        @(posedge clk);
        slew_set <= SLEW_OFF;
        pls(5'h08);
        chk_rd(ADDR_STATUS, 16'h000b, "cntup off");
        host.wr_reg(ADDR_CTRL, 16'h0001);
        wait_for(1'b0);
        `CHK("clear load", {TURNS_INIT_ONE, TURNS_INIT_ZERO}, {ld_p, ld_s})
        // turns registers hold matching values before enable
        host.wr_reg(ADDR_CTRL, 16'h0002);
        k = 0;
        repeat (6) begin
            @(posedge clk);
            #1 k += int'(tload === 1'b1);
        end
        `CHK("refused load", 0, k)
        @(posedge clk);
        lpe <= 1'b1;
        host.wr_reg(ADDR_CTRL, 16'h0002);
        wait_for(1'b0);
        `CHK("load", {11'h123, 11'h123}, {ld_p, ld_s})
        chk_rd(ADDR_CTRL, ZERO16, "we clear");
        host.wr_reg(ADDR_CTRL, 16'h0004);
        @(posedge clk);
        #1 `CHK("soft", 2'b01, {rel, lrst})
        wait_for(1'b1);
        `CHK("soft done", 1'b1, rocc)
        chk_rd(ADDR_CTRL, ZERO16, "soft rd");
        host.rd_reg(ADDR_STATUS, rv);
        `CHK("soft status", 16'h0002, rv)
        pls(5'h10);
        @(posedge clk);
        #1 `CHK("reset flag rd", 1'b0, rocc)
        host.wr_reg(ADDR_CTRL, 16'h0008);
        @(posedge clk);
        #1 `CHK("full", 2'b11, {rel, lrst})
        wait_for(1'b1);
        `CHK("full done", 1'b1, rocc)
        chk_rd(ADDR_CTRL, ZERO16, "full rd");
        give_verdict();
    end
endmodule // angle_sensor_status_control_regs_bench
